// ===== verilog/timer_pkg.sv
// Constants, control and state layouts of the 8-bit timer/counter
package timer_pkg;

  localparam int          CNT_W        = 8;
  localparam int          PRE_W        = 10;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
  localparam logic [7:0]  CNT_BOTTOM   = 8'h00;
  localparam logic [7:0]  CNT_RST      = 8'h00;
  localparam logic [7:0]  OCR_RST      = 8'h00;
  localparam logic        OC_RST       = 1'h0;

  localparam logic [2:0]  CS_STOP      = 3'h0;
  localparam logic [2:0]  CS_DIV1      = 3'h1;
  localparam logic [2:0]  CS_DIV8      = 3'h2;
  localparam logic [2:0]  CS_DIV64     = 3'h3;
  localparam logic [2:0]  CS_DIV256    = 3'h4;
  localparam logic [2:0]  CS_DIV1024   = 3'h5;
  localparam logic [2:0]  CS_EXT_FALL  = 3'h6;
  localparam logic [2:0]  CS_EXT_RISE  = 3'h7;

  localparam logic [9:0]  PRE_MASK8    = 10'h007;
  localparam logic [9:0]  PRE_MASK64   = 10'h03F;
  localparam logic [9:0]  PRE_MASK256  = 10'h0FF;
  localparam logic [9:0]  PRE_MASK1024 = 10'h3FF;

  localparam logic [2:0]  WGM_NORMAL   = 3'h0;
  localparam logic [2:0]  WGM_PC_FF    = 3'h1;
  localparam logic [2:0]  WGM_CTC      = 3'h2;
  localparam logic [2:0]  WGM_FAST_FF  = 3'h3;
  localparam logic [2:0]  WGM_PC_OCR   = 3'h5;
  localparam logic [2:0]  WGM_FAST_OCR = 3'h7;

  localparam logic [1:0]  COM_OFF      = 2'h0;
  localparam logic [1:0]  COM_TOGGLE   = 2'h1;
  localparam logic [1:0]  COM_CLEAR    = 2'h2;
  localparam logic [1:0]  COM_SET      = 2'h3;

  typedef enum logic {CNT_UP, CNT_DOWN} count_dir_e;

  typedef struct packed {
    logic [1:0] compare_output_mode;
    logic [1:0] waveform_mode_lo;
  } timer_control_a_s;

  typedef struct packed {
    logic       waveform_mode_hi;
    logic [2:0] tick_source_select;
  } timer_control_b_s;

  typedef struct packed {
    logic [7:0] timer_count_value;
    count_dir_e dir;
    logic [7:0] ocr_buf;
    logic [7:0] ocr_act;
    logic       compare_output_state;
    logic       overflow_flag;
    logic       compare_flag_a;
  } timer_state_s;

  typedef struct packed {
    logic [9:0] div_cnt;
    logic       ext_prev;
  } prescale_state_s;

endpackage

// ===== verilog/tick_prescaler.sv
// Tick source selection and prescaler for the timer
module tick_prescaler
  import timer_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic [2:0] tick_source_select,
  input  wire logic       ext_tick_pin,
  output logic            timer_tick
);

  prescale_state_s s_r;
  prescale_state_s s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.div_cnt  = s_r.div_cnt + 10'h001;
    s_nxt.ext_prev = ext_tick_pin;
    if (tick_source_select == CS_STOP) begin
      s_nxt.div_cnt = 10'h000;
    end
  end

  always_comb begin
    case (tick_source_select)
      CS_DIV1:     timer_tick = 1'b1;
      CS_DIV8:     timer_tick = (s_r.div_cnt & PRE_MASK8) == PRE_MASK8;
      CS_DIV64:    timer_tick = (s_r.div_cnt & PRE_MASK64) == PRE_MASK64;
      CS_DIV256:   timer_tick = (s_r.div_cnt & PRE_MASK256) == PRE_MASK256;
      CS_DIV1024:  timer_tick = s_r.div_cnt == PRE_MASK1024;
      CS_EXT_FALL: timer_tick = s_r.ext_prev & ~ext_tick_pin;
      CS_EXT_RISE: timer_tick = ~s_r.ext_prev & ext_tick_pin;
      default:     timer_tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // tick_prescaler

// ===== verilog/timer_counter_compare_output.sv
// 8-bit timer/counter with compare-output unit and pin override
module timer_counter_compare_output
  import timer_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire timer_control_a_s  timer_control_a,
  input  wire timer_control_b_s  timer_control_b,
  input  wire logic              force_compare_strobe,
  input  wire logic              ext_tick_pin,
  input  wire logic              count_wr_en,
  input  wire logic [CNT_W-1:0]  count_wr_data,
  input  wire logic              compare_wr_en,
  input  wire logic [CNT_W-1:0]  compare_wr_data,
  input  wire logic              overflow_clear,
  input  wire logic              compare_clear,
  input  wire logic              overflow_int_en,
  input  wire logic              compare_int_en,
  input  wire logic              overflow_int_ack,
  input  wire logic              compare_int_ack,
  input  wire logic              port_data_bit,
  input  wire logic              port_dir_bit,
  output logic [CNT_W-1:0]       timer_count_value,
  output logic [CNT_W-1:0]       compare_value_a,
  output logic                   top_ind,
  output logic                   bottom_ind,
  output logic                   compare_match_a,
  output logic                   overflow_flag,
  output logic                   compare_flag_a,
  output logic                   overflow_irq,
  output logic                   compare_irq,
  output logic                   compare_output_state,
  output logic                   pin_out,
  output logic                   pin_oe
);

  timer_state_s s_r;
  timer_state_s s_nxt;

  logic             timer_tick;
  logic [2:0]       waveform_mode_field;
  logic [1:0]       com;
  logic             mode_ctc;
  logic             mode_fast;
  logic             mode_pc;
  logic             mode_pwm;
  logic [CNT_W-1:0] top_val;
  logic             at_top;
  logic             at_bottom;
  logic             match;
  logic             ovf_set;
  logic             cmp_set;

  tick_prescaler u_prescaler (
    .mclk               (mclk),
    .srst               (srst),
    .tick_source_select (timer_control_b.tick_source_select),
    .ext_tick_pin       (ext_tick_pin),
    .timer_tick         (timer_tick)
  );

  // Mode decode
  assign waveform_mode_field = {timer_control_b.waveform_mode_hi,
                                timer_control_a.waveform_mode_lo};
  assign com       = timer_control_a.compare_output_mode;
  assign mode_ctc  = waveform_mode_field == WGM_CTC;
  assign mode_fast = (waveform_mode_field == WGM_FAST_FF) ||
                     (waveform_mode_field == WGM_FAST_OCR);
  assign mode_pc   = (waveform_mode_field == WGM_PC_FF) ||
                     (waveform_mode_field == WGM_PC_OCR);
  assign mode_pwm  = mode_fast | mode_pc;

  // Top value per mode
  always_comb begin
    case (waveform_mode_field)
      WGM_CTC:      top_val = s_r.ocr_act;
      WGM_PC_OCR:   top_val = s_r.ocr_act;
      WGM_FAST_OCR: top_val = s_r.ocr_act;
      default:      top_val = CNT_MAX;
    endcase
  end

  assign at_top    = s_r.timer_count_value == top_val;
  assign at_bottom = s_r.timer_count_value == CNT_BOTTOM;
  assign match     = s_r.timer_count_value == s_r.ocr_act;

  // Next state
  always_comb begin
    s_nxt   = s_r;
    ovf_set = 1'b0;
    cmp_set = 1'b0;

    // Compare value: immediate outside PWM, buffered at top in PWM
    if (compare_wr_en) begin
      s_nxt.ocr_buf = compare_wr_data;
      if (!mode_pwm) begin
        s_nxt.ocr_act = compare_wr_data;
      end
    end

    if (timer_tick) begin
      cmp_set = match;

      // Counting sequence
      if (mode_pc) begin
        if (s_r.dir == CNT_UP) begin
          if (at_top) begin
            s_nxt.dir               = CNT_DOWN;
            s_nxt.timer_count_value = s_r.timer_count_value - 8'h01;
            s_nxt.ocr_act           = s_r.ocr_buf;
          end else begin
            s_nxt.timer_count_value = s_r.timer_count_value + 8'h01;
          end
        end else begin
          if (at_bottom) begin
            s_nxt.dir               = CNT_UP;
            s_nxt.timer_count_value = s_r.timer_count_value + 8'h01;
            ovf_set                 = 1'b1;
          end else begin
            s_nxt.timer_count_value = s_r.timer_count_value - 8'h01;
          end
        end
      end else if (mode_fast) begin
        s_nxt.dir = CNT_UP;
        if (at_top) begin
          s_nxt.timer_count_value = CNT_BOTTOM;
          s_nxt.ocr_act           = s_r.ocr_buf;
          ovf_set                 = 1'b1;
        end else begin
          s_nxt.timer_count_value = s_r.timer_count_value + 8'h01;
        end
      end else if (mode_ctc) begin
        s_nxt.dir = CNT_UP;
        if (at_top) begin
          s_nxt.timer_count_value = CNT_BOTTOM;
        end else begin
          s_nxt.timer_count_value = s_r.timer_count_value + 8'h01;
        end
        ovf_set = s_r.timer_count_value == CNT_MAX;
      end else begin
        s_nxt.dir               = CNT_UP;
        s_nxt.timer_count_value = s_r.timer_count_value + 8'h01;
        ovf_set                 = s_r.timer_count_value == CNT_MAX;
      end

      // Compare output state actions
      if (mode_fast) begin
        if (match) begin
          case (com)
            COM_TOGGLE: begin
              if (timer_control_b.waveform_mode_hi) begin
                s_nxt.compare_output_state = ~s_r.compare_output_state;
              end
            end
            COM_CLEAR:  s_nxt.compare_output_state = 1'b0;
            COM_SET:    s_nxt.compare_output_state = 1'b1;
            default:    s_nxt.compare_output_state = s_r.compare_output_state;
          endcase
        end else if (at_top) begin
          case (com)
            COM_CLEAR: s_nxt.compare_output_state = 1'b1;
            COM_SET:   s_nxt.compare_output_state = 1'b0;
            default:   s_nxt.compare_output_state = s_r.compare_output_state;
          endcase
        end
      end else if (mode_pc) begin
        if (match) begin
          case (com)
            COM_TOGGLE: begin
              if (timer_control_b.waveform_mode_hi) begin
                s_nxt.compare_output_state = ~s_r.compare_output_state;
              end
            end
            COM_CLEAR:  s_nxt.compare_output_state = s_r.dir == CNT_DOWN;
            COM_SET:    s_nxt.compare_output_state = s_r.dir == CNT_UP;
            default:    s_nxt.compare_output_state = s_r.compare_output_state;
          endcase
        end
      end else if (match) begin
        case (com)
          COM_TOGGLE: s_nxt.compare_output_state = ~s_r.compare_output_state;
          COM_CLEAR:  s_nxt.compare_output_state = 1'b0;
          COM_SET:    s_nxt.compare_output_state = 1'b1;
          default:    s_nxt.compare_output_state = s_r.compare_output_state;
        endcase
      end
    end

    // Forced compare: action only, no flag and no counter clear
    if (force_compare_strobe && !mode_pwm) begin
      case (com)
        COM_TOGGLE: s_nxt.compare_output_state = ~s_r.compare_output_state;
        COM_CLEAR:  s_nxt.compare_output_state = 1'b0;
        COM_SET:    s_nxt.compare_output_state = 1'b1;
        default:    s_nxt.compare_output_state = s_r.compare_output_state;
      endcase
    end

    // CPU write has priority over clear and count
    if (count_wr_en) begin
      s_nxt.timer_count_value = count_wr_data;
    end

    // Flags: set wins over clear
    s_nxt.overflow_flag  = ovf_set |
      (s_r.overflow_flag & ~(overflow_clear | overflow_int_ack));
    s_nxt.compare_flag_a = cmp_set |
      (s_r.compare_flag_a & ~(compare_clear | compare_int_ack));
  end

  // State register; output state survives mode changes
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r.timer_count_value    <= CNT_RST;
      s_r.dir                  <= CNT_UP;
      s_r.ocr_buf              <= OCR_RST;
      s_r.ocr_act              <= OCR_RST;
      s_r.compare_output_state <= OC_RST;
      s_r.overflow_flag        <= 1'b0;
      s_r.compare_flag_a       <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Observation outputs
  assign timer_count_value    = s_r.timer_count_value;
  assign compare_value_a      = s_r.ocr_buf;
  assign top_ind              = s_r.timer_count_value == CNT_MAX;
  assign bottom_ind           = at_bottom;
  assign compare_match_a      = match;
  assign overflow_flag        = s_r.overflow_flag;
  assign compare_flag_a       = s_r.compare_flag_a;
  assign overflow_irq         = s_r.overflow_flag & overflow_int_en;
  assign compare_irq          = s_r.compare_flag_a & compare_int_en;
  assign compare_output_state = s_r.compare_output_state;

  // Pin override by output mode only, direction from port
  assign pin_out = (com != COM_OFF) ? s_r.compare_output_state : port_data_bit;
  assign pin_oe  = port_dir_bit;

endmodule // timer_counter_compare_output

// ===== bench/timer_pin_model.sv
// Shared pin model: resolves the pin level seen outside
module timer_pin_model (
  input  wire logic mclk,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_r = 1'h0;
  // Released pin shows the inverse of the last driven level
  always @(posedge mclk) begin
    if (pin_oe) begin
      last_r <= pin_out;
    end
  end
  assign pin_level = pin_oe ? pin_out : ~last_r;
endmodule // timer_pin_model

// ===== bench/timer_counter_compare_output_asserts.sv
// Port checks for the timer/counter and compare output
module timer_counter_compare_output_asserts
  import timer_pkg::*;
(
  input wire logic             mclk,
  input wire logic             srst,
  input wire timer_control_a_s timer_control_a,
  input wire timer_control_b_s timer_control_b,
  input wire logic             count_wr_en,
  input wire logic [CNT_W-1:0] count_wr_data,
  input wire logic             port_data_bit,
  input wire logic             port_dir_bit,
  input wire logic             overflow_int_en,
  input wire logic [CNT_W-1:0] timer_count_value,
  input wire logic             top_ind,
  input wire logic             bottom_ind,
  input wire logic             compare_match_a,
  input wire logic             overflow_flag,
  input wire logic             compare_flag_a,
  input wire logic             overflow_irq,
  input wire logic             compare_output_state,
  input wire logic             pin_out,
  input wire logic             pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] wgm;
  logic [2:0] sel;
  logic [1:0] com;
  assign wgm = {timer_control_b.waveform_mode_hi, timer_control_a.waveform_mode_lo};
  assign sel = timer_control_b.tick_source_select;
  assign com = timer_control_a.compare_output_mode;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_step;
    sel == CS_DIV1 && wgm == WGM_NORMAL && !count_wr_en;
  endsequence
  sequence s_wrap;
    s_step ##0 timer_count_value == CNT_MAX;
  endsequence
  a_ends_flagged: assert property (top_ind == (timer_count_value == CNT_MAX)
    && bottom_ind == (timer_count_value == CNT_BOTTOM)) else $error("top or bottom indication wrong");
  a_stop_holds: assert property (sel == CS_STOP && !count_wr_en |=> $stable(timer_count_value))
    else $error("counter moved while stopped");
  a_write_wins: assert property (count_wr_en |=> timer_count_value == $past(count_wr_data))
    else $error("counter write lost");
  a_step_one: assert property (s_step |=> timer_count_value == 8'($past(timer_count_value) + 8'h01))
    else $error("count step wrong");
  a_wrap_ovf: assert property (s_wrap |=> overflow_flag && timer_count_value == CNT_BOTTOM)
    else $error("overflow not flagged on wrap");
  a_ovf_irq: assert property (overflow_irq == (overflow_flag && overflow_int_en))
    else $error("overflow request wrong");
  a_off_keeps: assert property (com == COM_OFF |=> $stable(compare_output_state))
    else $error("output state changed with mode off");
  a_pin_source: assert property (pin_out == (com != COM_OFF ? compare_output_state : port_data_bit))
    else $error("pin source wrong");
  a_pin_dir: assert property (pin_oe == port_dir_bit)
    else $error("pin direction wrong");
  a_match_flag: assert property (sel == CS_DIV1 && compare_match_a |=> compare_flag_a)
    else $error("compare flag not set");
endmodule // timer_counter_compare_output_asserts

bind timer_counter_compare_output timer_counter_compare_output_asserts timer_counter_compare_output_asserts_i (
  .mclk, .srst, .timer_control_a, .timer_control_b, .count_wr_en, .count_wr_data, .port_data_bit,
  .port_dir_bit, .overflow_int_en, .timer_count_value, .top_ind, .bottom_ind, .compare_match_a,
  .overflow_flag, .compare_flag_a, .overflow_irq, .compare_output_state, .pin_out, .pin_oe);

// ===== bench/test_timer_counter_compare_output.sv
// Self-checking bench for the timer/counter with compare output
module test_timer_counter_compare_output
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] wgm;
    logic [2:0] sel;
    logic [7:0] start;
    logic [10:0] n;
    logic [7:0] cnt;
    logic       ovf;
  } row_s;
  localparam row_s ROWS [10] = '{
    '{WGM_PC_FF, CS_DIV1, 8'hFD, 11'h004, 8'hFD, 1'h0},
    '{WGM_NORMAL, CS_DIV1, 8'h10, 11'h005, 8'h15, 1'h0},
    '{WGM_NORMAL, CS_DIV1, 8'hFD, 11'h004, 8'h01, 1'h1},
    '{WGM_FAST_FF, CS_DIV1, 8'hFE, 11'h003, 8'h01, 1'h1},
    '{WGM_CTC, CS_DIV1, 8'hFD, 11'h004, 8'h00, 1'h1},
    '{WGM_NORMAL, CS_DIV8, 8'h10, 11'h010, 8'h12, 1'h0},
    '{WGM_NORMAL, CS_DIV64, 8'h40, 11'h040, 8'h41, 1'h0},
    '{WGM_NORMAL, CS_DIV256, 8'h80, 11'h100, 8'h81, 1'h0},
    '{WGM_NORMAL, CS_DIV1024, 8'hC0, 11'h400, 8'hC1, 1'h0},
    '{WGM_NORMAL, CS_STOP, 8'h33, 11'h009, 8'h33, 1'h0}};
  localparam logic [1:0] FORCE_COM [5] = '{COM_CLEAR, COM_SET, COM_TOGGLE, COM_TOGGLE, COM_OFF};
  localparam logic       FORCE_EXP [5] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
  logic             mclk = 1'h0;
  logic             srst = 1'h1;
  timer_control_a_s timer_control_a = 4'h0;
  timer_control_b_s timer_control_b = 4'h0;
  logic             force_compare_strobe = 1'h0, ext_tick_pin = 1'h0, count_wr_en = 1'h0, compare_wr_en = 1'h0;
  logic [7:0]       count_wr_data = 8'h00, compare_wr_data = 8'h00;
  logic             overflow_clear = 1'h0, compare_clear = 1'h0, overflow_int_en = 1'h0, compare_int_en = 1'h0;
  logic             overflow_int_ack = 1'h0, compare_int_ack = 1'h0, port_data_bit = 1'h0, port_dir_bit = 1'h0;
  logic [7:0]       timer_count_value, compare_value_a;
  logic             top_ind, bottom_ind, compare_match_a, overflow_flag, compare_flag_a, overflow_irq;
  logic             compare_irq, compare_output_state, pin_out, pin_oe, pin_level;
  int               errors = 0;
  int               checks = 0;
  int               cycles = 0;
  row_s             r;

  timer_counter_compare_output timer_counter_compare_output_i (.mclk, .srst, .timer_control_a,
    .timer_control_b, .force_compare_strobe, .ext_tick_pin, .count_wr_en, .count_wr_data, .compare_wr_en,
    .compare_wr_data, .overflow_clear, .compare_clear, .overflow_int_en, .compare_int_en, .overflow_int_ack,
    .compare_int_ack, .port_data_bit, .port_dir_bit, .timer_count_value, .compare_value_a, .top_ind,
    .bottom_ind, .compare_match_a, .overflow_flag, .compare_flag_a, .overflow_irq, .compare_irq,
    .compare_output_state, .pin_out, .pin_oe);
  timer_pin_model timer_pin_model_i (.mclk, .pin_out, .pin_oe, .pin_level);

  initial begin
    forever #50 mclk = ~mclk;
  end

  task print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // Runs n clock cycles with select s from the current edge, then stops
  task tick_run(input logic [2:0] s, input int n);
    timer_control_b.tick_source_select <= s;
    repeat (n) @(posedge mclk);
    timer_control_b.tick_source_select <= CS_STOP;
    @(posedge mclk);
    #1;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict;
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'h0;
    overflow_int_en <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      r = ROWS[i];
      @(posedge mclk);
      {timer_control_b.waveform_mode_hi, timer_control_a.waveform_mode_lo} <= r.wgm;
      count_wr_en <= 1'h1;
      count_wr_data <= r.start;
      overflow_clear <= 1'h1;
      @(posedge mclk);
      count_wr_en <= 1'h0;
      overflow_clear <= 1'h0;
      tick_run(r.sel, r.n);
      check("count", r.cnt, timer_count_value);
      check("overflow flag", {7'h00, r.ovf}, {7'h00, overflow_flag});
    end
    // Write in the same cycle as a tick
    @(posedge mclk);
    timer_control_b.tick_source_select <= CS_DIV1;
    count_wr_en <= 1'h1;
    count_wr_data <= 8'h80;
    @(posedge mclk);
    timer_control_b.tick_source_select <= CS_STOP;
    count_wr_en <= 1'h0;
    #1;
    check("written count", 8'h80, timer_count_value);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      timer_control_a.compare_output_mode <= FORCE_COM[i];
      force_compare_strobe <= 1'h1;
      @(posedge mclk);
      force_compare_strobe <= 1'h0;
      #1;
      check("forced state", {7'h00, FORCE_EXP[i]}, {7'h00, compare_output_state});
    end
    @(posedge mclk);
    port_dir_bit <= 1'h1;
    #1;
    check("pin port drive", 8'h00, {7'h00, pin_level});
    @(posedge mclk);
    timer_control_a.compare_output_mode <= COM_SET;
    {timer_control_b.waveform_mode_hi, timer_control_a.waveform_mode_lo} <= WGM_FAST_FF;
    #1;
    check("pin override", 8'h01, {7'h00, pin_level});
    @(posedge mclk);
    port_dir_bit <= 1'h0;
    {timer_control_b.waveform_mode_hi, timer_control_a.waveform_mode_lo} <= WGM_NORMAL;
    #1;
    check("pin enable", 8'h00, {7'h00, pin_oe});
    // Match by counting toggles the state and sets the flag
    @(posedge mclk);
    timer_control_a.compare_output_mode <= COM_TOGGLE;
    compare_wr_en <= 1'h1;
    compare_wr_data <= 8'h05;
    count_wr_en <= 1'h1;
    count_wr_data <= 8'h03;
    compare_clear <= 1'h1;
    compare_int_en <= 1'h1;
    @(posedge mclk);
    compare_wr_en <= 1'h0;
    count_wr_en <= 1'h0;
    compare_clear <= 1'h0;
    #1;
    check("compare value", 8'h05, compare_value_a);
    check("flag before match", 8'h00, {7'h00, compare_flag_a});
    @(posedge mclk);
    tick_run(CS_DIV1, 3);
    check("count after match", 8'h06, timer_count_value);
    check("compare flag", 8'h01, {7'h00, compare_flag_a});
    check("compare request", 8'h01, {7'h00, compare_irq});
    check("toggled state", 8'h00, {7'h00, compare_output_state});
    @(posedge mclk);
    compare_int_ack <= 1'h1;
    @(posedge mclk);
    compare_int_ack <= 1'h0;
    #1;
    check("flag after service", 8'h00, {7'h00, compare_flag_a});
    repeat (2) begin
      @(posedge mclk);
      timer_control_b.tick_source_select <= CS_EXT_RISE;
      ext_tick_pin <= 1'h1;
      @(posedge mclk);
      ext_tick_pin <= 1'h0;
    end
    tick_run(CS_EXT_RISE, 1);
    check("external ticks", 8'h08, timer_count_value);
    // Falling select ignores the rise, counts the fall
    @(posedge mclk);
    timer_control_b.tick_source_select <= CS_EXT_FALL;
    ext_tick_pin <= 1'h1;
    @(posedge mclk);
    ext_tick_pin <= 1'h0;
    tick_run(CS_EXT_FALL, 1);
    check("falling tick", 8'h09, timer_count_value);
    // Reset in mid-run with the state set
    @(posedge mclk);
    timer_control_a.compare_output_mode <= COM_SET;
    force_compare_strobe <= 1'h1;
    @(posedge mclk);
    force_compare_strobe <= 1'h0;
    srst <= 1'h1;
    repeat (2) @(posedge mclk);
    srst <= 1'h0;
    #1;
    check("state after reset", 8'h00, {7'h00, compare_output_state});
    @(posedge mclk);
    tick_run(CS_DIV1, 2);
    check("count after reset", 8'h02, timer_count_value);
    print_verdict;
  end
endmodule // test_timer_counter_compare_output
